// [design/msgbuf_ctrl.sv]
// Operation
// - idle receive 0000, armed receive 0010
// - accepted frame shows copying, then holding
// - frame into holding shows 0101, then overrun
// - armed buffer with enable requests interrupt when held
// - status top bit one means transmit buffer
// - idle transmit takes data; send code starts
// - success returns idle; failure keeps retrying
// - sent remote request moves to armed receive
// - await-remote answers remote frame then waits
// - send-then-await sends first, then awaits
// - in progress: only upper status bits writable
// - from crc field schedule best pending buffer
// - scheduled buffer cancellable until frame starts
// - displaced scheduled buffer returns to its pending send code
// - on error or lost arbitration reselect later
// - writes to busy bit ignored
// - busy bit set during copy, cleared after
// - rank by priority above buffer number, smallest wins
// - receive lock holds buffer until rearmed
`timescale 1ns/1ps
module msgbuf_ctrl
  import msgbuf_pkg::*;
#(
  parameter int N = NUM_BUF,
  parameter int COPY_LEN = COPY_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire engine_ev_s ev,
  input wire logic [N-1:0] irq_enable,
  output engine_rsp_s rsp_q,
  output logic [N-1:0] irq_req_q
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [3:0] st_q [N];
  logic [PRI_W-1:0] pri_q [N];
  logic [3:0] len_q [N];
  logic [31:0] id_q [N];
  logic [N-1:0] lock_q;
  logic lock_en_q;
  logic [31:0] global_accept_mask_q;

  // current transmitter and scheduled next buffer
  logic cur_v_q, nxt_v_q;
  logic [BUF_IDX_W-1:0] cur_q, nxt_q;

  // copy engine
  typedef enum logic [1:0] {CP_IDLE = 2'b00, CP_RUN = 2'b01, CP_DONE = 2'b11} copy_e;
  copy_e cp_q;
  logic [4:0] cp_cnt_q;
  logic [BUF_IDX_W-1:0] cp_buf_q;
  logic [31:0] hid_id_q;
  logic [3:0] hid_len_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic wr, rd;
  logic [BUF_IDX_W-1:0] widx;
  logic hit_st, hit_id, hit_ok;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign widx = paddr[5:2];
  assign hit_st = (paddr[11:6] == ADDR_BUF_BASE[11:6]) && (widx < BUF_IDX_W'(N));
  assign hit_id = (paddr[11:6] == ADDR_BUF_ID_BASE[11:6]) && (widx < BUF_IDX_W'(N));
  assign hit_ok = hit_st || hit_id || paddr == ADDR_CONFIG || paddr == ADDR_GLOBAL_ACCEPT_MASK;

  // ----------------------------------------------------------------
  // receive match, lowest number first
  // ----------------------------------------------------------------
  logic m_found, m_remote_tx;
  logic [BUF_IDX_W-1:0] m_idx;
  always_comb begin
    m_found = 1'b0;
    m_remote_tx = 1'b0;
    m_idx = '0;
    for (int i = 0; i < N; i++) begin
      if (!m_found && ((id_q[i] ^ ev.rx_id) & ~global_accept_mask_q) == 32'h0) begin
        if (!ev.rx_remote && !lock_q[i] &&
            (st_q[i] == ST_RX_ARMED || st_q[i] == ST_RX_HOLD)) begin
          m_found = 1'b1;
          m_idx = BUF_IDX_W'(i);
        end else if (ev.rx_remote && st_q[i] == ST_TX_AWAIT) begin
          m_found = 1'b1;
          m_remote_tx = 1'b1;
          m_idx = BUF_IDX_W'(i);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit pick among single-send and send-then-await buffers
  // ----------------------------------------------------------------
  logic [N-1:0] pend;
  logic [N*PRI_W-1:0] pri_flat;
  logic p_found;
  logic [BUF_IDX_W-1:0] p_idx;
  for (genvar g = 0; g < N; g++) begin : g_pend
    assign pend[g] = (st_q[g] == ST_TX_ONCE || st_q[g] == ST_TX_ONCE_AWAIT)
                     && !(cur_v_q && cur_q == BUF_IDX_W'(g));
    assign pri_flat[g*PRI_W +: PRI_W] = pri_q[g];
  end
  prio_pick #(.N(N)) u_pick (
    .req(pend),
    .pri(pri_flat),
    .found(p_found),
    .idx(p_idx)
  );
  logic [7:0] p_rank, n_rank;
  assign p_rank = {pri_q[p_idx], p_idx};
  assign n_rank = {pri_q[nxt_q], nxt_q};

  // ----------------------------------------------------------------
  // copy engine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cp_q <= CP_IDLE;
      cp_cnt_q <= '0;
      cp_buf_q <= '0;
      hid_id_q <= RST_ID;
      hid_len_q <= '0;
    end else begin
      unique case (cp_q)
        CP_IDLE: begin
          if (ev.rx_valid && m_found && !m_remote_tx) begin
            cp_q <= CP_RUN;
            cp_cnt_q <= 5'(COPY_LEN - 1);
            cp_buf_q <= m_idx;
            hid_id_q <= ev.rx_id;
            hid_len_q <= ev.rx_len;
          end
        end
        CP_RUN: begin
          if (cp_cnt_q == 5'h0) cp_q <= CP_DONE;
          else cp_cnt_q <= cp_cnt_q - 5'h1;
        end
        CP_DONE: cp_q <= CP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status, data and scheduling
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        st_q[i] <= ST_RX_IDLE;
        pri_q[i] <= '0;
        len_q[i] <= '0;
        id_q[i] <= RST_ID;
      end
      lock_q <= '0;
      lock_en_q <= 1'b0;
      global_accept_mask_q <= RST_GLOBAL_ACCEPT_MASK;
      cur_v_q <= 1'b0;
      nxt_v_q <= 1'b0;
      cur_q <= '0;
      nxt_q <= '0;
      irq_req_q <= '0;
    end else begin
      irq_req_q <= '0;
      // software writes
      if (wr && hit_st) begin
        if (st_q[widx][ST_BUSY_BIT] || (cp_q != CP_IDLE && cp_buf_q == widx)) begin
          st_q[widx][3:1] <= pwdata[3:1];
        end else begin
          st_q[widx] <= {pwdata[3:1], 1'b0};
          pri_q[widx] <= pwdata[FLD_PRI_LSB +: PRI_W];
          len_q[widx] <= pwdata[FLD_LEN_LSB +: 4];
        end
        if (pwdata[3:0] == ST_RX_ARMED) lock_q[widx] <= 1'b0;
        if (nxt_v_q && nxt_q == widx && pwdata[3:0] == ST_TX_IDLE) begin
          nxt_v_q <= 1'b0;
          st_q[widx] <= ST_TX_IDLE;
        end
      end
      if (wr && hit_id && !st_q[widx][ST_BUSY_BIT]) id_q[widx] <= pwdata;
      if (wr && paddr == ADDR_CONFIG) lock_en_q <= pwdata[CFG_LOCK_BIT];
      if (wr && paddr == ADDR_GLOBAL_ACCEPT_MASK) global_accept_mask_q <= pwdata;
      // receive copy: busy set at start, result at end
      if (cp_q == CP_IDLE && ev.rx_valid && m_found) begin
        if (m_remote_tx) begin
          st_q[m_idx] <= ST_TX_ONCE_AWAIT;
        end else begin
          st_q[m_idx][ST_BUSY_BIT] <= 1'b1;
        end
      end
      if (cp_q == CP_DONE) begin
        id_q[cp_buf_q] <= hid_id_q;
        len_q[cp_buf_q] <= hid_len_q;
        unique case (st_q[cp_buf_q][3:1])
          3'b001: st_q[cp_buf_q] <= ST_RX_HOLD;
          3'b010: st_q[cp_buf_q] <= ST_RX_OVERRUN;
          3'b011: st_q[cp_buf_q] <= ST_RX_OVERRUN;
          default: st_q[cp_buf_q] <= {st_q[cp_buf_q][3:1], 1'b0};
        endcase
        if (st_q[cp_buf_q][3:1] == 3'b001 && irq_enable[cp_buf_q]) begin
          irq_req_q[cp_buf_q] <= 1'b1;
        end
        if (lock_en_q) lock_q[cp_buf_q] <= 1'b1;
      end
      // scheduling from the crc field of the running frame
      if ((ev.crc_start || !cur_v_q) && p_found &&
          (!nxt_v_q || p_rank < n_rank)) begin
        if (nxt_v_q) st_q[nxt_q] <= {st_q[nxt_q][3:1], 1'b0};
        nxt_v_q <= 1'b1;
        nxt_q <= p_idx;
        st_q[p_idx][ST_BUSY_BIT] <= 1'b1;
      end
      if (ev.frame_start && nxt_v_q && !cur_v_q) begin
        cur_v_q <= 1'b1;
        cur_q <= nxt_q;
        nxt_v_q <= 1'b0;
      end
      // end of a transmission
      if (cur_v_q && ev.tx_ok) begin
        cur_v_q <= 1'b0;
        unique case (st_q[cur_q][3:1])
          3'b111: st_q[cur_q] <= ST_TX_AWAIT;
          3'b110: st_q[cur_q] <= id_q[cur_q][FLD_RTR_BIT] ? ST_RX_ARMED : ST_TX_IDLE;
          default: st_q[cur_q] <= {st_q[cur_q][3:1], 1'b0};
        endcase
      end
      if (cur_v_q && ev.tx_fail) begin
        // back to pending so a fresh pick happens on the next cycle; tx_req still waits for bus_idle
        cur_v_q <= 1'b0;
        st_q[cur_q] <= {st_q[cur_q][3:1], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // engine request and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q.tx_req <= nxt_v_q && !cur_v_q && ev.bus_idle;
      rsp_q.tx_buf <= nxt_q;
      rsp_q.copy_busy <= cp_q != CP_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_ok;
      if (rd) begin
        prdata <= '0;
        if (hit_st) begin
          prdata <= {19'h0, lock_q[widx], len_q[widx], pri_q[widx], st_q[widx]};
        end else if (hit_id) begin
          prdata <= id_q[widx];
        end else if (paddr == ADDR_CONFIG) begin
          prdata <= {31'h0, lock_en_q};
        end else if (paddr == ADDR_GLOBAL_ACCEPT_MASK) begin
          prdata <= global_accept_mask_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_copy_len;
    @(posedge pclk) disable iff (!presetn)
      (cp_q == CP_IDLE && ev.rx_valid && m_found && !m_remote_tx)
      |=> (cp_q == CP_RUN) [*8];
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy ended early");

  property p_busy_shown;
    @(posedge pclk) disable iff (!presetn)
      (cp_q == CP_RUN) |-> st_q[cp_buf_q][ST_BUSY_BIT];
  endproperty
  a_busy_shown: assert property (p_busy_shown) else $error("busy not shown in copy");

  property p_hold_after;
    @(posedge pclk) disable iff (!presetn)
      (cp_q == CP_DONE && st_q[cp_buf_q] == 4'h3) |=> st_q[$past(cp_buf_q)] == ST_RX_HOLD;
  endproperty
  a_hold_after: assert property (p_hold_after) else $error("hold not reached");

  property p_overrun;
    @(posedge pclk) disable iff (!presetn)
      (cp_q == CP_DONE && st_q[cp_buf_q] == 4'h5) |=> st_q[$past(cp_buf_q)] == ST_RX_OVERRUN;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not reached");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (cp_q == CP_DONE && st_q[cp_buf_q] == 4'h3 && irq_enable[cp_buf_q])
      |=> irq_req_q[$past(cp_buf_q)];
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt request");

  property p_one_sched;
    @(posedge pclk) disable iff (!presetn)
      nxt_v_q |-> st_q[nxt_q][ST_BUSY_BIT];
  endproperty
  a_one_sched: assert property (p_one_sched) else $error("scheduled buffer not busy");

  property p_tx_ok;
    @(posedge pclk) disable iff (!presetn)
      (cur_v_q && ev.tx_ok && st_q[cur_q] == 4'hD && !id_q[cur_q][FLD_RTR_BIT])
      |=> st_q[$past(cur_q)] == ST_TX_IDLE && !cur_v_q;
  endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("not idle after send");

  property p_await;
    @(posedge pclk) disable iff (!presetn)
      (cur_v_q && ev.tx_ok && st_q[cur_q] == 4'hF) |=> st_q[$past(cur_q)] == ST_TX_AWAIT;
  endproperty
  a_await: assert property (p_await) else $error("await not entered");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bad pready timing");

endmodule

// [include/msgbuf_pkg.sv]
package msgbuf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_BUF = 15;
  localparam int BUF_IDX_W = 4;
  localparam int PRI_W = 4;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // state codes of the four-bit status field
  // ----------------------------------------------------------------
  localparam logic [3:0] ST_RX_IDLE = 4'h0;
  localparam logic [3:0] ST_RX_ARMED = 4'h2;
  localparam logic [3:0] ST_RX_HOLD = 4'h4;
  localparam logic [3:0] ST_RX_OVERRUN = 4'h6;
  localparam logic [3:0] ST_TX_IDLE = 4'h8;
  localparam logic [3:0] ST_TX_AWAIT = 4'hA;
  localparam logic [3:0] ST_TX_ONCE = 4'hC;
  localparam logic [3:0] ST_TX_ONCE_AWAIT = 4'hE;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TX_BIT = 3;

  // ----------------------------------------------------------------
  // register map, a status word and an id word per buffer plus a config word and a global accept mask word
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_BUF_BASE = 12'h000;
  localparam logic [11:0] ADDR_BUF_ID_BASE = 12'h040;
  localparam logic [11:0] ADDR_CONFIG = 12'h080;
  localparam logic [11:0] ADDR_GLOBAL_ACCEPT_MASK = 12'h084;
  localparam int CFG_LOCK_BIT = 0;
  // status word: [3:0] state, [7:4] priority, [11:8] length, [12] lock
  localparam int FLD_PRI_LSB = 4;
  localparam int FLD_LEN_LSB = 8;
  localparam int FLD_LOCK_BIT = 12;
  // id word: [28:0] identifier, [31] remote request bit
  localparam int FLD_RTR_BIT = 31;
  localparam logic [31:0] RST_ID = 32'h0000_0000;
  localparam logic [31:0] RST_GLOBAL_ACCEPT_MASK = 32'h0000_0000;
  // minimum cycles for a copy from the hidden buffer
  localparam int COPY_CYCLES = 17;

  // ----------------------------------------------------------------
  // bit engine events
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_valid;       // frame validated, hidden buffer ready
    logic rx_remote;      // that frame is a remote frame
    logic [31:0] rx_id;
    logic [3:0] rx_len;
    logic crc_start;      // current frame reached its crc field
    logic frame_start;    // next frame begins on the bus
    logic tx_ok;          // frame sent successfully
    logic tx_fail;        // error or arbitration lost
    logic bus_idle;       // reception or error signalling ended
  } engine_ev_s;

  typedef struct packed {
    logic tx_req;
    logic [BUF_IDX_W-1:0] tx_buf;
    logic copy_busy;
  } engine_rsp_s;

endpackage

// [design/prio_pick.sv]
`timescale 1ns/1ps
module prio_pick
  import msgbuf_pkg::*;
#(
  parameter int N = NUM_BUF
) (
  input wire logic [N-1:0] req,
  input wire logic [N*PRI_W-1:0] pri,
  output logic found,
  output logic [BUF_IDX_W-1:0] idx
);
  // ----------------------------------------------------------------
  // smallest {priority, number} wins; ties go to the lower number
  // ----------------------------------------------------------------
  logic [7:0] best;
  always_comb begin
    found = 1'b0;
    idx = '0;
    best = 8'hFF;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || {pri[i*PRI_W +: PRI_W], 4'(i)} < best)) begin
        found = 1'b1;
        idx = BUF_IDX_W'(i);
        best = {pri[i*PRI_W +: PRI_W], 4'(i)};
      end
    end
  end
endmodule

// [bench/engine_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// can bit engine stand-in
// ----------------------------------------
module engine_model
  import msgbuf_pkg::*;
#(
  parameter int FRAME = 30
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire engine_rsp_s rsp,
  output engine_ev_s ev
);
  logic stall = 1'b0;
  logic fail_next = 1'b0;
  logic [BUF_IDX_W-1:0] log_q[$];

  task automatic rx(input logic [31:0] id, input logic [3:0] len, input logic rem);
    ev.rx_id <= id;
    ev.rx_len <= len;
    ev.rx_remote <= rem;
    ev.rx_valid <= 1'b1;
    @(posedge pclk);
    ev.rx_valid <= 1'b0;
    // released lines show the inverse so a stale copy is never trusted
    ev.rx_id <= ~id;
    ev.rx_len <= ~len;
  endtask

  initial begin
    ev = '0;
    ev.bus_idle = 1'b1;
    forever begin
      @(posedge pclk);
      if (presetn === 1'b1 && rsp.tx_req === 1'b1 && !stall) begin
        log_q.push_back(rsp.tx_buf);
        ev.frame_start <= 1'b1;
        ev.bus_idle <= 1'b0;
        @(posedge pclk);
        ev.frame_start <= 1'b0;
        repeat (FRAME) @(posedge pclk);
        ev.crc_start <= 1'b1;
        @(posedge pclk);
        ev.crc_start <= 1'b0;
        repeat (4) @(posedge pclk);
        ev.tx_fail <= fail_next;
        ev.tx_ok <= !fail_next;
        @(posedge pclk);
        ev.tx_fail <= 1'b0;
        ev.tx_ok <= 1'b0;
        ev.bus_idle <= 1'b1;
        fail_next <= 1'b0;
      end
    end
  end
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench
  import msgbuf_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic last_err;
  logic [NUM_BUF-1:0] irq_en = 15'h0001;
  logic [NUM_BUF-1:0] irq;
  engine_ev_s ev;
  engine_rsp_s rsp;
  int failures = 0;
  int n_compared = 0;
  int irq_cnt = 0;
  int n0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) irq_cnt <= irq_cnt + $countones(irq);

  msgbuf_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ev(ev), .irq_enable(irq_en), .rsp_q(rsp), .irq_req_q(irq));
  engine_model i_eng (.pclk(pclk), .presetn(presetn), .rsp(rsp), .ev(ev));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [11:0] sa(input int b);
    return ADDR_BUF_BASE + 12'(4 * b);
  endfunction

  function automatic logic [11:0] ia(input int b);
    return ADDR_BUF_ID_BASE + 12'(4 * b);
  endfunction

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("pready", 32'h0, 32'h1);
      final_report();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle keeps back-to-back calls from driving psel twice
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_st(input int b, input logic [3:0] e, input string nm, input int lim);
    int n;
    n = 0;
    do begin
      apb(1'b0, sa(b), 32'h0);
      n++;
    end while (r[3:0] !== e && n < lim);
    chk(nm, 32'(r[3:0]), 32'(e));
    if (lim > 1 && r[3:0] !== e) final_report();
  endtask

  task automatic txgo(input int b, input logic [3:0] pri, input logic [3:0] code);
    wr(sa(b), 32'(ST_TX_IDLE));
    wr(sa(b), 32'({pri, code}));
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wait_st(14, 4'h0, "reset st", 1);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'(last_err), 32'h1);
    wr(ADDR_GLOBAL_ACCEPT_MASK, 32'h0);
    wr(ia(0), 32'h123);
    wr(sa(0), 32'h2);
    wait_st(0, 4'h2, "armed", 1);
    i_eng.rx(32'h123, 4'h4, 1'b0);
    wait_st(0, 4'h3, "copying", 1);
    chk("copy busy", 32'(rsp.copy_busy), 32'h1);
    wait_st(0, 4'h4, "held", 40);
    chk("len", 32'(r[11:8]), 32'h4);
    chk("irq", 32'(irq_cnt), 32'h1);
    i_eng.rx(32'h123, 4'h2, 1'b0);
    wait_st(0, 4'h5, "ovr copy", 1);
    wait_st(0, 4'h6, "overrun", 40);
    chk("irq ovr", 32'(irq_cnt), 32'h1);
    wr(sa(0), 32'h2);
    wr(sa(1), 32'h3);
    wait_st(1, 4'h2, "busy bit", 1);
    wr(ADDR_CONFIG, 32'h1);
    wr(ia(1), 32'h123);
    i_eng.rx(32'h123, 4'h1, 1'b0);
    wait_st(0, 4'h4, "lock 1st", 40);
    i_eng.rx(32'h123, 4'h1, 1'b0);
    wait_st(1, 4'h4, "lock 2nd", 40);
    wait_st(0, 4'h4, "locked", 1);
    apb(1'b0, ia(0), 32'h0);
    chk("locked id", r, 32'h123);
    wr(ADDR_CONFIG, 32'h0);
    wr(sa(0), 32'h0);
    wr(sa(1), 32'h0);
    // plain send, busy lock, retry after failure
    wr(ia(2), 32'h55);
    wr(sa(2), 32'(ST_TX_IDLE));
    wait_st(2, ST_TX_IDLE, "tx idle", 1);
    wr(sa(2), 32'(ST_TX_ONCE));
    wait_st(2, {ST_TX_ONCE[3:1], 1'b1}, "in prog", 20);
    wr(ia(2), 32'h77);
    apb(1'b0, ia(2), 32'h0);
    chk("id lock", r, 32'h55);
    wait_st(2, ST_TX_IDLE, "sent", 40);
    n0 = i_eng.log_q.size();
    i_eng.fail_next = 1'b1;
    wr(sa(2), 32'(ST_TX_ONCE));
    wait_st(2, ST_TX_IDLE, "retry", 80);
    chk("attempts", 32'(i_eng.log_q.size() - n0), 32'h2);
    // remote request, then send-then-await
    wr(ia(3), 32'h8000_0033);
    txgo(3, 4'h0, ST_TX_ONCE);
    wait_st(3, 4'h2, "rtr rx", 40);
    // the answer has its remote bit clear, so that bit must be a don't care
    wr(ADDR_GLOBAL_ACCEPT_MASK, 32'h8000_0000);
    i_eng.rx(32'h33, 4'h1, 1'b0);
    wait_st(3, 4'h4, "rtr answer", 40);
    wr(ADDR_GLOBAL_ACCEPT_MASK, 32'h0);
    wr(ia(4), 32'h44);
    txgo(4, 4'h0, ST_TX_ONCE_AWAIT);
    wait_st(4, ST_TX_AWAIT, "await", 40);
    i_eng.rx(32'h44, 4'h0, 1'b1);
    wait_st(4, {ST_TX_ONCE_AWAIT[3:1], 1'b1}, "answer", 20);
    wait_st(4, ST_TX_AWAIT, "re-await", 40);
    chk("answer buf", 32'(i_eng.log_q[$]), 32'h4);
    // stalled bus: cancel, rank, displace
    i_eng.stall = 1'b1;
    n0 = i_eng.log_q.size();
    txgo(7, 4'h0, ST_TX_ONCE);
    txgo(5, 4'h2, ST_TX_ONCE);
    txgo(6, 4'h1, ST_TX_ONCE);
    wr(sa(7), 32'(ST_TX_IDLE));
    wait_st(7, ST_TX_IDLE, "cancel", 1);
    wait_st(6, {ST_TX_ONCE[3:1], 1'b1}, "sched", 10);
    txgo(8, 4'h0, ST_TX_ONCE);
    wait_st(6, ST_TX_ONCE, "displaced", 10);
    i_eng.stall = 1'b0;
    wait_st(5, ST_TX_IDLE, "drain", 200);
    chk("count", 32'(i_eng.log_q.size() - n0), 32'h3);
    chk("first", 32'(i_eng.log_q[n0]), 32'h8);
    chk("second", 32'(i_eng.log_q[n0 + 1]), 32'h6);
    chk("third", 32'(i_eng.log_q[n0 + 2]), 32'h5);
    final_report();
  end
endmodule
